// ### hw/adcrf_pkg.sv
// constants shared by the converter result-status logic
package adcrf_pkg;
   // ===========================================================
   // sizes
   localparam int NUM_CHAN   = 8;
   localparam int CHAN_W     = 3;
   localparam int DATA_W     = 10;
   localparam int ADDR_W     = 8;
   // ===========================================================
   // register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_MODE   = 8'h04;
   localparam logic [7:0] OFF_CHEN   = 8'h10;
   localparam logic [7:0] OFF_CHDIS  = 8'h14;
   localparam logic [7:0] OFF_CHSTAT = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1C;
   localparam logic [7:0] OFF_LAST   = 8'h20;
   localparam logic [7:0] OFF_EVT    = 8'h30;
   localparam logic [7:0] OFF_MASK   = 8'h34;
   localparam logic [7:0] OFF_CHRES  = 8'h40;
   localparam logic [7:0] OFF_CHRES_END = 8'h5C;
   // ===========================================================
   // field positions
   localparam int CTRL_START_BIT = 0;
   localparam int MODE_SLEEP_BIT = 0;
   localparam int ST_DONE_LSB    = 0;
   localparam int ST_OVR_LSB     = 8;
   localparam int ST_READY_BIT   = 16;
   localparam int ST_GOVR_BIT    = 17;
   localparam int LAST_CHAN_LSB  = 12;
   localparam int EVT_W          = 3;
   localparam int EVT_STORE_BIT  = 0;
   localparam int EVT_OVR_BIT    = 1;
   localparam int EVT_GOVR_BIT   = 2;
   // ===========================================================
   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : adcrf_pkg

// ### hw/adcrf_result_flags.sv
// converter result registers, status flags and their bus slave
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module adcrf_result_flags
   import adcrf_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // conversion core
   input  wire logic                coreEoc,
   input  wire logic [CHAN_W-1:0]   coreChan,
   input  wire logic [DATA_W-1:0]   coreData,
   output logic                     startConv,
   output logic [NUM_CHAN-1:0]      chanEnable,
   output logic                     sleepMode,
   output logic                     irq,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready
);

   // ===========================================================
   // state
   typedef struct packed {
      // write channel
      logic                             awHave;
      logic                             wHave;
      logic [ADDR_W-1:0]                awAddr;
      logic [31:0]                      wData;
      logic [3:0]                       wStrb;

      // bus handshake outputs
      logic                             awReady;
      logic                             wReady;
      logic                             bValid;
      logic [1:0]                       bResp;
      logic                             arReady;
      logic                             rValid;
      logic [1:0]                       rResp;
      logic [31:0]                      rData;

      // channel flags
      logic [NUM_CHAN-1:0]              chEn;
      logic [NUM_CHAN-1:0]              done;
      logic [NUM_CHAN-1:0]              ovr;
      logic                             ready;
      logic                             govr;

      // stored results
      logic [CHAN_W-1:0]                lastChan;
      logic [DATA_W-1:0]                lastData;
      logic [NUM_CHAN-1:0][DATA_W-1:0]  chRes;

      // control and interrupt
      logic                             sleepSet;
      logic                             sleepAct;
      logic                             start;
      logic [EVT_W-1:0]                 evt;
      logic [EVT_W-1:0]                 mask;
      logic                             irq;
   } adcrf_state_t;

   adcrf_state_t q;
   adcrf_state_t d;

   // ===========================================================
   // next state
   always_comb begin
      // write decode
      logic                  doWrite;
      logic                  wrOk;
      logic [31:0]           wMask;
      logic [31:0]           wVal;

      // read decode
      logic                  arTake;
      logic                  rdOk;
      logic [31:0]           rVal;
      logic                  rdStatus;
      logic                  rdLast;
      logic                  rdEvt;
      logic [NUM_CHAN-1:0]   rdChan;

      // flag work
      logic [NUM_CHAN-1:0]   disMask;
      logic [NUM_CHAN-1:0]   enEff;
      logic                  store;
      logic                  newOvr;
      logic                  newGovr;

      // register indices
      logic [CHAN_W-1:0]     rIdx;
      logic [CHAN_W-1:0]     wIdx;

      d        = q;

      // write decode defaults
      doWrite  = 1'b0;
      wrOk     = 1'b0;
      wMask    = '0;
      wVal     = '0;

      // read decode defaults
      arTake   = 1'b0;
      rdOk     = 1'b0;
      rVal     = '0;
      rdStatus = 1'b0;
      rdLast   = 1'b0;
      rdEvt    = 1'b0;
      rdChan   = '0;

      // flag defaults
      disMask  = '0;
      enEff    = '0;
      store    = 1'b0;
      newOvr   = 1'b0;
      newGovr  = 1'b0;

      // word index of each address
      rIdx     = s_axi_araddr[CHAN_W+1:2];
      wIdx     = q.awAddr[CHAN_W+1:2];

      // start is a one-cycle pulse
      d.start  = 1'b0;

      // ========================================================
      // write channel: address and data taken in either order
      if (s_axi_awvalid && q.awReady) begin
         d.awHave = 1'b1;
         d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wReady) begin
         d.wHave = 1'b1;
         d.wData = s_axi_wdata;
         d.wStrb = s_axi_wstrb;
      end
      if (q.bValid && s_axi_bready) begin
         d.bValid = 1'b0;
      end
      if (q.awHave && q.wHave && !q.bValid) begin
         doWrite  = 1'b1;
         d.awHave = 1'b0;
         d.wHave  = 1'b0;
         d.bValid = 1'b1;
      end
      for (int b = 0; b < 4; b++) begin
         wMask[8*b +: 8] = {8{q.wStrb[b]}};
      end
      wVal = q.wData & wMask;

      if (doWrite) begin
         wrOk = 1'b1;
         unique case (q.awAddr)
            OFF_CTRL: begin
               d.start = wVal[CTRL_START_BIT];
            end
            OFF_MODE: begin
               if (q.wStrb[0]) begin
                  d.sleepSet = wVal[MODE_SLEEP_BIT];
               end
            end
            OFF_CHEN: begin
               d.chEn = q.chEn | wVal[NUM_CHAN-1:0];
            end
            OFF_CHDIS: begin
               disMask = wVal[NUM_CHAN-1:0];
            end
            OFF_MASK: begin
               if (q.wStrb[0]) begin
                  d.mask = wVal[EVT_W-1:0];
               end
            end
            default: begin
               // read-only or unmapped: refused, nothing changes
               wrOk = 1'b0;
            end
         endcase
         d.bResp = wrOk ? RESP_OKAY : RESP_SLVERR;
      end

      // ========================================================
      // read channel: side effects happen in the accept cycle
      if (q.rValid && s_axi_rready) begin
         d.rValid = 1'b0;
      end
      if (s_axi_arvalid && q.arReady) begin
         arTake   = 1'b1;
         d.rValid = 1'b1;
      end
      if (arTake) begin
         rdOk = 1'b1;
         if (s_axi_araddr >= OFF_CHRES &&
             s_axi_araddr <= OFF_CHRES_END &&
             s_axi_araddr[1:0] == 2'h0) begin
            rdChan[rIdx] = 1'b1;
            rVal[DATA_W-1:0] = q.chRes[rIdx];
         end else begin
            unique case (s_axi_araddr)
               OFF_MODE: begin
                  rVal[MODE_SLEEP_BIT] = q.sleepSet;
               end
               OFF_CHSTAT: begin
                  rVal[NUM_CHAN-1:0] = q.chEn;
               end
               OFF_STATUS: begin
                  rdStatus = 1'b1;
                  rVal[ST_DONE_LSB +: NUM_CHAN] = q.done;
                  rVal[ST_OVR_LSB +: NUM_CHAN]  = q.ovr;
                  rVal[ST_READY_BIT] = q.ready;
                  rVal[ST_GOVR_BIT]  = q.govr;
               end
               OFF_LAST: begin
                  rdLast = 1'b1;
                  rVal[DATA_W-1:0] = q.lastData;
                  rVal[LAST_CHAN_LSB +: CHAN_W] = q.lastChan;
               end
               OFF_EVT: begin
                  rdEvt = 1'b1;
                  rVal[EVT_W-1:0] = q.evt;
               end
               OFF_MASK: begin
                  rVal[EVT_W-1:0] = q.mask;
               end
               default: begin
                  // write-only or unmapped: zero data and no side effects
                  rdOk = 1'b0;
               end
            endcase
         end
         d.rData = rVal;
         d.rResp = rdOk ? RESP_OKAY : RESP_SLVERR;
      end

      // ========================================================
      // channel enables; a disable in this cycle already counts
      d.chEn = d.chEn & ~disMask;
      enEff  = q.chEn & ~disMask;
      // disabled channel stores nothing and flags nothing
      store  = coreEoc && enEff[coreChan];

      // ========================================================
      // software clears first, hardware sets after so sets win
      d.done = q.done & ~rdChan;
      if (rdLast) begin
         d.done = '0;
      end
      if (rdStatus) begin
         d.ovr  = '0;
         d.govr = 1'b0;
      end
      if (rdLast) begin
         d.ready = 1'b0;
      end
      if (rdEvt) begin
         d.evt = '0;
      end

      if (store) begin
         d.chRes[coreChan] = coreData;
         d.lastData        = coreData;
         d.lastChan        = coreChan;

         // overruns look at flag values from before this edge
         d.done[coreChan]  = 1'b1;
         // channel reads and disables elsewhere do not block this
         d.ready           = 1'b1;
         newOvr            = q.done[coreChan];
         newGovr           = q.ready;
      end
      if (newOvr) begin
         d.ovr[coreChan] = 1'b1;
      end
      if (newGovr) begin
         // also taken with a status read or channel read this cycle
         d.govr = 1'b1;
      end

      // ========================================================
      // event register feeding the interrupt
      if (store) begin
         d.evt[EVT_STORE_BIT] = 1'b1;
      end
      if (newOvr) begin
         d.evt[EVT_OVR_BIT] = 1'b1;
      end
      if (newGovr) begin
         d.evt[EVT_GOVR_BIT] = 1'b1;
      end
      d.irq = |(d.evt & d.mask);

      // ========================================================
      // sleep: an idle core only drops after a finished conversion;
      // software gets there soonest by writing sleep then start
      if (!d.sleepSet) begin
         d.sleepAct = 1'b0;
      end else if (coreEoc) begin
         d.sleepAct = 1'b1;
      end

      // ready outputs follow from the next busy state
      d.awReady = !d.awHave && !d.bValid;
      d.wReady  = !d.wHave && !d.bValid;
      d.arReady = !d.rValid;
   end

   // ===========================================================
   // registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ===========================================================
   // outputs, all straight from the state register
   // core side
   assign startConv     = q.start;
   assign chanEnable    = q.chEn;
   assign sleepMode     = q.sleepAct;
   assign irq           = q.irq;

   // write channel
   assign s_axi_awready = q.awReady;
   assign s_axi_wready  = q.wReady;
   assign s_axi_bresp   = q.bResp;
   assign s_axi_bvalid  = q.bValid;

   // read channel
   assign s_axi_arready = q.arReady;
   assign s_axi_rdata   = q.rData;
   assign s_axi_rresp   = q.rResp;
   assign s_axi_rvalid  = q.rValid;

endmodule : adcrf_result_flags

`default_nettype wire

// ### test/adcrf_core_model.sv
// conversion core stand-in: start-driven or bench-fired results
`timescale 1ns/1ps
`default_nettype none
module adcrf_core_model
   import adcrf_pkg::*;
#(
   parameter int                CONV_LAT = 4,
   parameter logic [DATA_W-1:0] CONV_VAL = 10'h2A5
)(
   input  wire logic              clk,
   input  wire logic              startConv,
   input  wire logic              fire,
   input  wire logic [CHAN_W-1:0] fireChan,
   input  wire logic [DATA_W-1:0] fireData,
   output logic                   coreEoc,
   output logic [CHAN_W-1:0]      coreChan,
   output logic [DATA_W-1:0]      coreData
);
   int                cnt = 0;
   logic [DATA_W-1:0] lastQ = '0;
   always @(posedge clk) begin
      if (startConv) cnt <= CONV_LAT;
      else if (cnt > 0) cnt <= cnt - 1;
      if (coreEoc) lastQ <= coreData;
   end
   // off-pulse lines show junk so a stale value can never pass as data
   always_comb begin
      coreEoc  = fire || cnt == 1;
      coreChan = fire ? fireChan : cnt == 1 ? '0 : ~lastQ[CHAN_W-1:0];
      coreData = fire ? fireData : cnt == 1 ? CONV_VAL : ~lastQ;
   end
endmodule : adcrf_core_model
`default_nettype wire

// ### test/adcrf_result_flags_asserts.sv
// bus and core-side output checks for the result-status block
`timescale 1ns/1ps
`default_nettype none
module adcrf_result_flags_asserts
   import adcrf_pkg::*;
(
   input wire logic                clk,
   input wire logic                sys_rst,
   input wire logic                coreEoc,
   input wire logic                startConv,
   input wire logic [NUM_CHAN-1:0] chanEnable,
   input wire logic                sleepMode,
   input wire logic [ADDR_W-1:0]   s_axi_araddr,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic [31:0]         s_axi_rdata,
   input wire logic [1:0]          s_axi_rresp,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready,
   input wire logic                s_axi_awvalid,
   input wire logic                s_axi_awready,
   input wire logic                s_axi_wvalid,
   input wire logic                s_axi_wready,
   input wire logic                s_axi_bvalid
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire logic              tk = s_axi_arvalid && s_axi_arready;
   wire logic [ADDR_W-1:0] ra = s_axi_araddr;
   a_sleep_eoc:
   assert property ($rose(sleepMode) |-> $past(coreEoc))
      else $error("sleep entered without a finished conversion");
   a_last_fields:
   assert property (tk && ra == OFF_LAST |=>
      s_axi_rdata[31:15] == '0 && s_axi_rdata[11:10] == '0)
      else $error("last result has stray bits");
   a_chres_clean:
   assert property (tk && ra >= OFF_CHRES && ra <= OFF_CHRES_END &&
      ra[1:0] == 2'h0 |=>
      s_axi_rresp == RESP_OKAY && s_axi_rdata[31:DATA_W] == '0)
      else $error("channel result read malformed");
   a_unmapped_rd:
   assert property (tk && ra == 8'hFC |=>
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
      else $error("unmapped read not refused");
   a_rd_hold:
   assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   a_rd_one_beat:
   assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid && s_axi_arready)
      else $error("read answer repeated");
   a_ar_blocked:
   assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");
   a_wr_answer:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer late or early");
   a_en_by_write:
   assert property ($changed(chanEnable) |-> $rose(s_axi_bvalid))
      else $error("enables moved without a write");
   a_start_pulse:
   assert property (startConv |=> !startConv)
      else $error("start longer than one cycle");
endmodule : adcrf_result_flags_asserts
bind adcrf_result_flags adcrf_result_flags_asserts chk (.clk, .sys_rst,
   .coreEoc, .startConv, .chanEnable, .sleepMode, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid);
`default_nettype wire

// ### test/adcrf_result_flags_tb.sv
// self-checking bench for the result-status block
`timescale 1ns/1ps
`default_nettype none
module adcrf_result_flags_tb import adcrf_pkg::*;;
   typedef struct {logic [13:0] e; logic [7:0] a; logic [31:0] x;} adcrf_row_t;
   localparam logic [31:0] RDY = 32'h1 << ST_READY_BIT;
   localparam logic [31:0] GOV = 32'h1 << ST_GOVR_BIT;
   localparam int          O = ST_OVR_LSB;
   localparam logic [9:0]  CONV = 10'h2A5;
   logic                clk = 0, sys_rst = 1, fire = 0, awV = 0, wV = 0;
   logic                bRdy = 0, arV = 0, rRdy = 0;
   logic [7:0]          awA = '0, arA = '0;
   logic [31:0]         wD = '0, rD;
   logic [CHAN_W-1:0]   fCh = '0, cCh;
   logic [DATA_W-1:0]   fDat = '0, cDat;
   logic [NUM_CHAN-1:0] chEn;
   logic [1:0]          bResp, rResp;
   logic                eoc, awRdy, wRdy, bV, arRdy, rV, start, sleep, irq;
   int                  miscompares = 0, n_tests = 0;
   adcrf_row_t          rows [6];
   always #20 clk = ~clk;
   adcrf_result_flags uut (.clk(clk), .sys_rst(sys_rst), .coreEoc(eoc),
      .coreChan(cCh), .coreData(cDat), .startConv(start), .chanEnable(chEn),
      .sleepMode(sleep), .irq(irq), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
      .s_axi_awready(awRdy), .s_axi_wdata(wD), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bResp),
      .s_axi_bvalid(bV), .s_axi_bready(bRdy), .s_axi_araddr(arA),
      .s_axi_arvalid(arV), .s_axi_arready(arRdy), .s_axi_rdata(rD),
      .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rRdy));
   adcrf_core_model #(.CONV_VAL(CONV)) core (.clk(clk), .startConv(start),
      .fire(fire), .fireChan(fCh), .fireData(fDat), .coreEoc(eoc),
      .coreChan(cCh), .coreData(cDat));
   // ===========================================================
   // helpers
   function automatic logic [13:0] ev(input int c, input int d);
      return {1'b1, 3'(c), 10'(d)};
   endfunction : ev
   function automatic logic [31:0] b(input int i);
      return 32'h1 << i;
   endfunction : b
   function automatic logic [31:0] lst(input int c, input int d);
      return (32'(c) << LAST_CHAN_LSB) | 32'(d);
   endfunction : lst
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run;
      if (miscompares == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   // an event rides alongside the bus edge that acts
   task automatic fr(input logic [13:0] e);
      {fire, fCh, fDat} <= e;
      @(posedge clk);
      fire <= 0;
      @(posedge clk);
   endtask : fr
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [13:0] e = '0, input logic [1:0] ws = 0);
      bit ga = 0;
      bit gw = 0;
      awA <= a; wD <= d; awV <= 1; wV <= 1; bRdy <= 1;
      do begin
         @(posedge clk);
         if (awRdy && !ga) begin ga = 1; awV <= 0; end
         if (wRdy && !gw) begin gw = 1; wV <= 0; end
      end while (!(ga && gw));
      {fire, fCh, fDat} <= e;
      do begin @(posedge clk); fire <= 0; end while (!bV);
      bRdy <= 0;
      chk(bResp, ws);
      repeat (2) @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input logic [13:0] e = '0, input logic [1:0] rs = 0);
      arA <= a; arV <= 1; rRdy <= 1;
      {fire, fCh, fDat} <= e;
      do begin @(posedge clk); fire <= 0; end while (!arRdy);
      arV <= 0;
      do @(posedge clk); while (!rV);
      rRdy <= 0;
      chk({rResp, rD}, {rs, x});
      repeat (2) @(posedge clk);
   endtask : rd
   // ===========================================================
   // sequence
   initial begin
      repeat (2500) @(posedge clk);
      miscompares++;
      complete_run();
   end
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 0;
      @(posedge clk);
      chk(chEn, 0);
      rd(OFF_STATUS, 0);
      wr(OFF_CHEN, 32'hFF);
      wr(OFF_MASK, 7);
      rows = '{'{ev(0, 'h3FF), OFF_CHRES, 'h3FF}, '{0, OFF_STATUS, RDY},
         '{0, OFF_LAST, lst(0, 'h3FF)}, '{ev(3, 'h155), OFF_STATUS, b(3) | RDY},
         '{0, OFF_LAST, lst(3, 'h155)}, '{0, OFF_STATUS, 0}};
      foreach (rows[i]) begin
         fr(rows[i].e);
         rd(rows[i].a, rows[i].x);
      end
      chk(irq, 1);
      wr(OFF_MASK, 0);
      chk(irq, 0);
      wr(OFF_MASK, 7);
      rd(OFF_EVT, 1);
      chk(irq, 0);
      fr(ev(1, 'h11));
      fr(ev(1, 'h22));
      rd(OFF_STATUS, b(1) | b(O + 1) | RDY | GOV);
      rd(OFF_STATUS, b(1) | RDY);
      rd(OFF_EVT, 7);
      rd(OFF_LAST, lst(1, 'h22));
      fr(ev(2, 'h33));
      rd(OFF_STATUS, b(2) | RDY, ev(2, 'h44));
      rd(OFF_CHRES + 8, 'h44);
      rd(OFF_STATUS, b(O + 2) | RDY | GOV, ev(2, 'h55));
      rd(OFF_LAST, lst(2, 'h55));
      rd(OFF_STATUS, GOV, ev(3, 'h66));
      rd(OFF_STATUS, b(3) | RDY);
      rd(OFF_LAST, lst(3, 'h66));
      fr(ev(5, 'h77));
      rd(OFF_CHRES + 16, 0, ev(5, 'h88));
      rd(OFF_STATUS, b(5) | b(O + 5) | RDY | GOV);
      rd(OFF_LAST, lst(5, 'h88));
      fr(ev(7, 'h1AA));
      wr(OFF_CHDIS, 32'h40, ev(7, 'h2BB));
      chk(chEn, 8'hBF);
      rd(OFF_STATUS, b(7) | b(O + 7) | RDY | GOV);
      rd(OFF_LAST, lst(7, 'h2BB));
      wr(OFF_CHDIS, 32'h01, ev(7, 'h3CC));
      rd(OFF_STATUS, b(7) | RDY);
      rd(OFF_CHRES + 28, 'h3CC, ev(6, 'h0DD));
      rd(OFF_STATUS, RDY);
      rd(OFF_CHRES + 24, 0);
      rd(8'hFC, 0, 0, RESP_SLVERR);
      wr(OFF_STATUS, 32'hFFFF, 0, RESP_SLVERR);
      rd(OFF_STATUS, RDY);
      wr(OFF_CHEN, 1);
      rd(OFF_CHSTAT, 'hBF);
      rd(OFF_MASK, 7);
      wr(OFF_MODE, 1);
      rd(OFF_MODE, 1);
      chk(sleep, 0);
      wr(OFF_CTRL, 1);
      for (int i = 0; i < 20 && !sleep; i++) @(posedge clk);
      chk(sleep, 1);
      rd(OFF_CHRES, CONV);
      sys_rst <= 1;
      repeat (2) @(posedge clk);
      sys_rst <= 0;
      @(posedge clk);
      chk({sleep, chEn}, 0);
      rd(OFF_STATUS, 0);
      complete_run();
   end
endmodule : adcrf_result_flags_tb
`default_nettype wire
